// ### bench/master_pair_model.sv
// behavioural pair of redundant bus masters feeding the redundancy switch
// assumes the bench sets traffic, counter and telegram enables and command bytes
`timescale 1ns/10ps
`default_nettype none

module master_pair_model (
  input wire logic clk,
  input wire logic rst,
  input wire logic [1:0] bus_en,
  input wire logic [1:0] cnt_en,
  input wire logic [1:0] tel_en,
  input wire logic [7:0] cmd_a,
  input wire logic [7:0] cmd_b,
  output logic [1:0] valid,
  output logic [1:0] act,
  output logic [1:0] tel,
  output logic [15:0] cmd_o,
  output logic [15:0] alive_o
);
  logic [2:0] ph;
  logic [15:0] cnt;

  // image every 8 cycles while traffic runs
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      ph <= 3'h0;
      cnt <= 16'h0000;
      valid <= 2'h0;
      act <= 2'h0;
      tel <= 2'h0;
    end else begin
      ph <= ph + 3'h1;
      for (int i = 0; i < 2; i++) begin
        valid[i] <= (ph == 3'h0) && bus_en[i];
        act[i] <= (ph == 3'h0) && bus_en[i];
        tel[i] <= (ph == 3'h0) && tel_en[i];
        if (ph == 3'h0 && bus_en[i] && cnt_en[i]) begin
          cnt[i*8 +: 8] <= cnt[i*8 +: 8] + 8'h01;
        end
      end
    end
  end

  // image bytes 0 and 1 only while valid, inverted otherwise
  assign cmd_o = {valid[1] ? cmd_b : ~cmd_b, valid[0] ? cmd_a : ~cmd_a};
  assign alive_o = {valid[1] ? cnt[15:8] : ~cnt[15:8], valid[0] ? cnt[7:0] : ~cnt[7:0]};
endmodule : master_pair_model

`default_nettype wire

// ### bench/testbench.sv
// self-checking bench of the redundancy switch
// assumes a 4-cycle millisecond tick and the master pair model
`timescale 1ns/10ps
`default_nettype none

module testbench;
  logic clk;
  logic rst;
  logic [1:0] bus_en, cnt_en, tel_en, trig;
  logic [7:0] cmd_a, cmd_b, steps, st_a, st_b, ec_a, ec_b;
  logic [15:0] wd, cmd_o, alive_o;
  logic [6:0] addr, st_addr;
  logic auto, sel_b, addr_ok;
  logic [1:0] valid, act, tel;
  int fail_count = 0;
  int checks_done = 0;
  int lim;
  logic [7:0] cv [5] = '{8'h01, 8'h03, 8'h01, 8'h00, 8'h01};
  logic ce [5] = '{1'b0, 1'b1, 1'b1, 1'b1, 1'b0};

  master_pair_model m (.clk(clk), .rst(rst), .bus_en(bus_en), .cnt_en(cnt_en),
    .tel_en(tel_en), .cmd_a(cmd_a), .cmd_b(cmd_b), .valid(valid), .act(act),
    .tel(tel), .cmd_o(cmd_o), .alive_o(alive_o));

  redundancy_switch #(.TICK_CYCLES(4)) DUT (.CLK_SYS(clk), .RST(rst),
    .OUT_VALID_A(valid[0]), .OUT_CMD_A(cmd_o[7:0]), .OUT_ALIVE_A(alive_o[7:0]),
    .OUT_VALID_B(valid[1]), .OUT_CMD_B(cmd_o[15:8]), .OUT_ALIVE_B(alive_o[15:8]),
    .BUS_ACT_A(act[0]), .BUS_ACT_B(act[1]), .ALIVE_TEL_A(tel[0]), .ALIVE_TEL_B(tel[1]),
    .TRIG_MODE(trig), .APP_TIMEOUT_STEPS(steps), .WATCHDOG_MS(wd), .ADDR_SWITCH(addr),
    .MODE_AUTO(auto), .SEL_B(sel_b), .STATION_ADDR(st_addr), .ADDR_VALID(addr_ok),
    .IN_STATE_A(st_a), .IN_ECHO_A(ec_a), .IN_STATE_B(st_b), .IN_ECHO_B(ec_b));

  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end

  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask : cyc

  task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
    checks_done++;
    if (got !== exp) begin
      fail_count++;
      $display("FAIL %s expected %h seen %h", what, exp, got);
    end
  endtask : chk

  task automatic chk_st(input logic a, input logic b, input logic s);
    chk("state byte A", {4'h0, b, a, s, 1'b1}, st_a);
    chk("state byte B", {4'h0, b, a, s, 1'b1}, st_b);
  endtask : chk_st

  task automatic wait_sel(input logic exp, input int n);
    for (int i = 0; i < n && sel_b !== exp; i++) cyc(1);
    chk("position", {7'h00, exp}, {7'h00, sel_b});
  endtask : wait_sel

  task automatic restart(input logic [1:0] mode, input logic [1:0] bus, input logic [1:0] cn);
    rst = 1'b1;
    trig = mode;
    bus_en = bus;
    cnt_en = cn;
    tel_en = 2'h0;
    cmd_b = 8'h00;
    cyc(12);
    rst = 1'b0;
    cyc(1);
  endtask : restart

  task automatic results;
    $display("counts: %0d checks, %0d mismatches", checks_done, fail_count);
    if (fail_count == 0 && checks_done > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask : results

  initial begin
    #(50 * 20000);
    fail_count++;
    results();
  end

  initial begin
    rst = 1'b1;
    trig = 2'h0;
    steps = 8'h00;
    wd = 16'h0000;
    addr = 7'h63;
    auto = 1'b0;
    bus_en = 2'h0;
    cnt_en = 2'h0;
    tel_en = 2'h0;
    cmd_a = 8'h00;
    cmd_b = 8'h00;
    cyc(12);
    chk("state in reset", 8'h00, st_a);
    rst = 1'b0;
    cyc(5);
    chk("address", 8'h63, {1'b0, st_addr});
    chk("address ok", 8'h01, {7'h00, addr_ok});
    addr = 7'h64;
    cyc(5);
    chk("address bad", 8'h00, {7'h00, addr_ok});
    chk("address held", 8'h63, {1'b0, st_addr});
    $display("test address done");

    restart(2'h0, 2'b10, 2'b00);
    wait_sel(1'b1, 40);
    bus_en = 2'b11;
    cyc(20);
    chk_st(1'b1, 1'b1, 1'b1);
    $display("test protocol start done");

    restart(2'h0, 2'b11, 2'b00);
    cyc(20);
    chk("position", 8'h00, {7'h00, sel_b});
    bus_en = 2'b10;
    cyc(80);
    chk("position", 8'h00, {7'h00, sel_b});
    bus_en = 2'b00;
    cyc(80);
    auto = 1'b1;
    cyc(40);
    chk("position", 8'h00, {7'h00, sel_b});
    bus_en = 2'b10;
    wait_sel(1'b1, 40);
    auto = 1'b0;
    for (int i = 0; i < 5; i++) begin
      cmd_b = cv[i];
      cyc(20);
      chk("manual position", {7'h00, ce[i]}, {7'h00, sel_b});
    end
    $display("test manual done");

    for (int k = 0; k < 2; k++) begin
      wd = (k == 0) ? 16'h000a : 16'h0028;
      lim = (wd / 2 > 10) ? wd / 2 : 10;
      restart(2'h0, 2'b11, 2'b00);
      auto = 1'b1;
      cyc(30);
      bus_en = 2'b10;
      cyc(lim * 4 - 16);
      chk("bus loss early", 8'h00, {7'h00, sel_b});
      wait_sel(1'b1, 32);
    end
    $display("test bus loss done");

    for (int k = 0; k < 2; k++) begin
      steps = (k == 0) ? 8'h00 : 8'h05;
      lim = (k == 0) ? 200 : 50;
      restart(2'h1, 2'b11, 2'b00);
      auto = 1'b1;
      cyc(lim * 4 + 100);
      chk_st(1'b0, 1'b0, 1'b0);
      cnt_en = 2'b10;
      wait_sel(1'b1, 40);
      cnt_en = 2'b11;
      cyc(40);
      while (valid[0] !== 1'b1) cyc(1);
      cyc(4);
      chk_st(1'b1, 1'b1, 1'b1);
      chk("echo A", m.cnt[7:0], ec_a);
      chk("echo B", m.cnt[15:8], ec_b);
      cnt_en = 2'b01;
      cyc(lim * 4 - 24);
      chk("app early", 8'h01, {7'h00, sel_b});
      wait_sel(1'b0, 48);
    end
    $display("test application done");

    restart(2'h2, 2'b11, 2'b00);
    cyc(60);
    chk("position", 8'h00, {7'h00, sel_b});
    tel_en = 2'b10;
    wait_sel(1'b1, 40);
    cmd_a = 8'h01;
    wait_sel(1'b0, 20);
    cmd_a = 8'h00;
    $display("test network done");
    results();
  end
endmodule : testbench

`default_nettype wire

// ### core/master_supervisor.sv
// per-master supervision: command edges, alive counter, bus traffic timer
// assumes image, traffic and telegram strobes from logic on the same clock
`timescale 1ns/10ps
`default_nettype none
`include "redsw_consts.svh"

module master_supervisor (
  input wire logic clk,
  input wire logic rst,
  input wire logic tick,
  input wire logic img_valid,
  input wire logic [7:0] img_cmd,
  input wire logic [7:0] img_alive,
  input wire logic bus_act,
  input wire logic alive_tel,
  input wire logic [1:0] trig_mode,
  input wire logic [`RS_MS_W-1:0] bus_lim,
  input wire logic [`RS_MS_W-1:0] app_lim,
  output logic to_a,
  output logic to_b,
  output logic alive,
  output logic failed,
  output logic [7:0] echo
);

  redsw_pkg::sup_state_t q;
  redsw_pkg::sup_state_t d;
  logic bus_ok;
  logic app_ok;

  always_comb begin
    d = q;
    d.to_a = 1'b0;
    d.to_b = 1'b0;
    // millisecond timers, saturating
    if (tick && q.bus_cnt != `RS_MS_SAT) begin
      d.bus_cnt = q.bus_cnt + 16'h0001;
    end
    if (tick && q.armed && q.app_cnt != `RS_MS_SAT) begin
      d.app_cnt = q.app_cnt + 16'h0001;
    end
    if (bus_act) begin
      d.bus_seen = 1'b1;
      d.bus_cnt = '0;
    end
    if (img_valid) begin
      d.seen = 1'b1;
      d.to_a = img_cmd[`RS_CMD_TO_A] && !q.prev_cmd[`RS_CMD_TO_A];
      d.to_b = img_cmd[`RS_CMD_TO_B] && !q.prev_cmd[`RS_CMD_TO_B];
      d.prev_cmd = img_cmd[1:0];
      d.prev_alive = img_alive;
      d.echo = img_alive;
      if (trig_mode == `RS_TRIG_APP && q.seen && img_alive != q.prev_alive) begin
        d.armed = 1'b1;
        d.app_cnt = '0;
      end
    end
    if (trig_mode == `RS_TRIG_NET && alive_tel) begin
      d.armed = 1'b1;
      d.app_cnt = '0;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

  always_comb begin
    bus_ok = q.bus_seen && q.bus_cnt < bus_lim;
    app_ok = q.armed && q.app_cnt < app_lim;
    unique case (trig_mode)
      `RS_TRIG_PROTO: alive = bus_ok;
      `RS_TRIG_APP: alive = bus_ok && app_ok;
      `RS_TRIG_NET: alive = app_ok;
      default: alive = bus_ok;
    endcase
    failed = (q.bus_seen && !bus_ok) || (trig_mode != `RS_TRIG_PROTO && q.armed && !app_ok);
  end

  assign to_a = q.to_a;
  assign to_b = q.to_b;
  assign echo = q.echo;

  property p_arm;
    @(posedge clk) disable iff (rst)
      trig_mode == `RS_TRIG_APP && img_valid && q.seen && img_alive != q.prev_alive |=> q.armed;
  endproperty
  a_arm: assert property (p_arm) else $error("alive supervision not armed by change");

  property p_no_arm;
    @(posedge clk) disable iff (rst)
      !q.armed && !img_valid && !alive_tel |=> !q.armed;
  endproperty
  a_no_arm: assert property (p_no_arm) else $error("alive supervision armed without cause");

  property p_edge;
    @(posedge clk) disable iff (rst)
      img_valid && img_cmd[`RS_CMD_TO_B] && !q.prev_cmd[`RS_CMD_TO_B] |=> to_b ##1 !to_b;
  endproperty
  a_edge: assert property (p_edge) else $error("rising command bit not seen once");

  property p_level;
    @(posedge clk) disable iff (rst)
      img_valid && q.prev_cmd[`RS_CMD_TO_A] |=> !to_a;
  endproperty
  a_level: assert property (p_level) else $error("held command bit retriggered");

endmodule : master_supervisor

`default_nettype wire

// ### core/pin_sync.sv
// two-stage synchroniser for the address switch and mode pins
// assumes asynchronous pins, one system clock
`timescale 1ns/10ps
`default_nettype none

module pin_sync (
  input wire logic clk,
  input wire logic rst,
  input wire logic [7:0] pin_in,
  output logic [7:0] pin_out
);

  redsw_pkg::sync_state_t q;
  redsw_pkg::sync_state_t d;

  always_comb begin
    d = q;
    d.s1 = pin_in;
    d.s2 = q.s1;
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

  assign pin_out = q.s2;

endmodule : pin_sync

`default_nettype wire

// ### core/redundancy_switch.sv
// bus master redundancy switch: routes one segment to master A or B
// assumes image strobes from the slave protocol engine on the same clock,
// address switch and mode switch as asynchronous pins
//
// Behaviour
// - protocol mode start: first connected master wins
// - one station address 0-99 for both
// - automatic switch-over only in automatic mode
// - automatic switch-over only to alive standby
// - bus loss: half watchdog, at least 10 ms
// - stalled alive counter switches after application timeout
// - both masters failed: keep position
// - application timeout in 10 ms steps, default 200
// - application mode start: first alive master wins
// - output image: commands, alive counter, reserved bytes
// - rising bit 0 selects A, bit 1 B
// - manual commands obeyed in both modes; a command to A wins over one to B in the same cycle
// - alive supervision armed by first counter change in application mode, by an alive telegram in network mode
// - input image: state bits, echo, reserved bytes
// - state bits: run, position, alive A, alive B
// - echo alive counter of each valid image, two cycles later
// - network mode start: first alive telegram wins
`timescale 1ns/10ps
`default_nettype none
`include "redsw_consts.svh"

module redundancy_switch #(
  parameter int unsigned TICK_CYCLES = `RS_TICK_US * `RS_CLK_MHZ
) (
  input wire logic CLK_SYS,
  input wire logic RST,
  input wire logic OUT_VALID_A,
  input wire logic [7:0] OUT_CMD_A,
  input wire logic [7:0] OUT_ALIVE_A,
  input wire logic OUT_VALID_B,
  input wire logic [7:0] OUT_CMD_B,
  input wire logic [7:0] OUT_ALIVE_B,
  input wire logic BUS_ACT_A,
  input wire logic BUS_ACT_B,
  input wire logic ALIVE_TEL_A,
  input wire logic ALIVE_TEL_B,
  input wire logic [1:0] TRIG_MODE,
  input wire logic [7:0] APP_TIMEOUT_STEPS,
  input wire logic [15:0] WATCHDOG_MS,
  input wire logic [`RS_ADDR_W-1:0] ADDR_SWITCH,
  input wire logic MODE_AUTO,
  output logic SEL_B,
  output logic [`RS_ADDR_W-1:0] STATION_ADDR,
  output logic ADDR_VALID,
  output logic [7:0] IN_STATE_A,
  output logic [7:0] IN_ECHO_A,
  output logic [7:0] IN_STATE_B,
  output logic [7:0] IN_ECHO_B
);

  redsw_pkg::top_state_t q;
  redsw_pkg::top_state_t d;

  logic [7:0] pins_s;
  logic [`RS_ADDR_W-1:0] addr_s;
  logic auto_s;
  logic [`RS_MS_W-1:0] wd_half;
  logic [`RS_MS_W-1:0] bus_lim;
  logic [`RS_MS_W-1:0] app_lim;
  logic [1:0] valid_v;
  logic [1:0] bus_v;
  logic [1:0] tel_v;
  logic [7:0] cmd_v [2];
  logic [7:0] alv_v [2];
  logic [1:0] to_a_v;
  logic [1:0] to_b_v;
  logic [1:0] alive_v;
  logic [1:0] failed_v;
  logic [7:0] echo_v [2];
  logic man_a;
  logic man_b;
  logic act_fail;
  logic other_alive;
  logic auto_go;

  pin_sync u_pins (
    .clk(CLK_SYS),
    .rst(RST),
    .pin_in({MODE_AUTO, ADDR_SWITCH}),
    .pin_out(pins_s)
  );

  assign addr_s = pins_s[`RS_ADDR_W-1:0];
  assign auto_s = pins_s[`RS_ADDR_W];

  // supervision limits in milliseconds
  always_comb begin
    wd_half = WATCHDOG_MS >> 1;
    bus_lim = (wd_half < `RS_BUS_MIN_MS) ? `RS_BUS_MIN_MS : wd_half;
    if (APP_TIMEOUT_STEPS == 8'h00) begin
      app_lim = `RS_APP_DEF_MS;
    end else begin
      app_lim = 16'({8'h00, APP_TIMEOUT_STEPS} * `RS_APP_STEP_MS);
    end
  end

  // only bytes 0 and 1 of each output image are carried; the rest is reserved
  assign valid_v = {OUT_VALID_B, OUT_VALID_A};
  assign bus_v = {BUS_ACT_B, BUS_ACT_A};
  assign tel_v = {ALIVE_TEL_B, ALIVE_TEL_A};
  assign cmd_v[0] = OUT_CMD_A;
  assign cmd_v[1] = OUT_CMD_B;
  assign alv_v[0] = OUT_ALIVE_A;
  assign alv_v[1] = OUT_ALIVE_B;

  // one supervisor per master
  for (genvar i = 0; i < 2; i++) begin : g_master
    master_supervisor u_sup (
      .clk(CLK_SYS),
      .rst(RST),
      .tick(q.tick),
      .img_valid(valid_v[i]),
      .img_cmd(cmd_v[i]),
      .img_alive(alv_v[i]),
      .bus_act(bus_v[i]),
      .alive_tel(tel_v[i]),
      .trig_mode(TRIG_MODE),
      .bus_lim(bus_lim),
      .app_lim(app_lim),
      .to_a(to_a_v[i]),
      .to_b(to_b_v[i]),
      .alive(alive_v[i]),
      .failed(failed_v[i]),
      .echo(echo_v[i])
    );
  end

  always_comb begin
    man_a = |to_a_v;
    man_b = (|to_b_v) && !man_a;
    act_fail = q.sel_b ? failed_v[1] : failed_v[0];
    other_alive = q.sel_b ? alive_v[0] : alive_v[1];
    auto_go = auto_s && act_fail && other_alive;
  end

  always_comb begin
    d = q;
    // millisecond tick
    d.tick = 1'b0;
    if (q.tick_cnt == `RS_TICK_W'(TICK_CYCLES - 1)) begin
      d.tick_cnt = '0;
      d.tick = 1'b1;
    end else begin
      d.tick_cnt = q.tick_cnt + 1'b1;
    end
    // switch position
    unique case (q.phase)
      redsw_pkg::PH_INIT: begin
        if (man_a || man_b) begin
          d.sel_b = man_b;
          d.phase = redsw_pkg::PH_RUN;
        end else if (alive_v[0]) begin
          d.sel_b = 1'b0;
          d.phase = redsw_pkg::PH_RUN;
        end else if (alive_v[1]) begin
          d.sel_b = 1'b1;
          d.phase = redsw_pkg::PH_RUN;
        end
      end
      redsw_pkg::PH_RUN: begin
        if (man_a) begin
          d.sel_b = 1'b0;
        end else if (man_b) begin
          d.sel_b = 1'b1;
        end else if (auto_go) begin
          d.sel_b = !q.sel_b;
        end
      end
    endcase
    // station address, shared by both masters
    if (addr_s <= `RS_ADDR_MAX) begin
      d.addr = addr_s;
      d.addr_ok = 1'b1;
    end else begin
      d.addr_ok = 1'b0;
    end
    // input images
    d.state_a = '0;
    d.state_a[7:4] = `RS_ST_RSVD;
    d.state_a[`RS_ST_RUN] = 1'b1;
    d.state_a[`RS_ST_POS] = d.sel_b;
    d.state_a[`RS_ST_ALIVE_A] = alive_v[0];
    d.state_a[`RS_ST_ALIVE_B] = alive_v[1];
    d.state_b = d.state_a;
    d.echo_a = echo_v[0];
    d.echo_b = echo_v[1];
  end

  always_ff @(posedge CLK_SYS or posedge RST) begin
    if (RST) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

  assign SEL_B = q.sel_b;
  assign STATION_ADDR = q.addr;
  assign ADDR_VALID = q.addr_ok;
  assign IN_STATE_A = q.state_a;
  assign IN_STATE_B = q.state_b;
  assign IN_ECHO_A = q.echo_a;
  assign IN_ECHO_B = q.echo_b;

  default clocking cb @(posedge CLK_SYS); endclocking
  default disable iff (RST);

  property p_init_both;
    q.phase == redsw_pkg::PH_INIT && !man_a && !man_b && alive_v[0] && alive_v[1]
      |=> !SEL_B && q.phase == redsw_pkg::PH_RUN;
  endproperty
  a_init_both: assert property (p_init_both) else $error("start with both alive not A");

  property p_init_b;
    q.phase == redsw_pkg::PH_INIT && !man_a && !man_b && !alive_v[0] && alive_v[1] |=> SEL_B;
  endproperty
  a_init_b: assert property (p_init_b) else $error("start with only B alive not B");

  property p_init_none;
    q.phase == redsw_pkg::PH_INIT && !man_a && !man_b && alive_v == 2'h0
      |=> $stable(SEL_B) && q.phase == redsw_pkg::PH_INIT;
  endproperty
  a_init_none: assert property (p_init_none) else $error("start moved with none alive");

  property p_manual_only;
    q.phase == redsw_pkg::PH_RUN && !man_a && !man_b && !auto_s |=> $stable(SEL_B);
  endproperty
  a_manual_only: assert property (p_manual_only) else $error("moved outside automatic mode");

  property p_standby_dead;
    q.phase == redsw_pkg::PH_RUN && !man_a && !man_b && !other_alive |=> $stable(SEL_B);
  endproperty
  a_standby_dead: assert property (p_standby_dead) else $error("moved to dead standby");

  property p_auto;
    q.phase == redsw_pkg::PH_RUN && !man_a && !man_b && auto_s && act_fail && other_alive
      |=> SEL_B != $past(SEL_B);
  endproperty
  a_auto: assert property (p_auto) else $error("automatic switch-over missed");

  property p_manual_a;
    man_a |=> !SEL_B ##1 IN_STATE_A[`RS_ST_POS] == SEL_B;
  endproperty
  a_manual_a: assert property (p_manual_a) else $error("manual command to A ignored");

  property p_manual_b;
    man_b |=> SEL_B;
  endproperty
  a_manual_b: assert property (p_manual_b) else $error("manual command to B ignored");

  property p_echo;
    OUT_VALID_A |-> ##2 IN_ECHO_A == $past(OUT_ALIVE_A, 2);
  endproperty
  a_echo: assert property (p_echo) else $error("alive counter echo wrong");

  property p_state;
    1'b1 |=> IN_STATE_A[`RS_ST_POS] == SEL_B && IN_STATE_A[7:4] == `RS_ST_RSVD
      && IN_STATE_A[`RS_ST_RUN] && IN_STATE_B == IN_STATE_A
      && IN_STATE_A[`RS_ST_ALIVE_A] == $past(alive_v[0])
      && IN_STATE_A[`RS_ST_ALIVE_B] == $past(alive_v[1]);
  endproperty
  a_state: assert property (p_state) else $error("state byte inconsistent");

  property p_addr;
    ADDR_VALID |-> STATION_ADDR <= `RS_ADDR_MAX;
  endproperty
  a_addr: assert property (p_addr) else $error("station address out of range");

  property p_app_def;
    APP_TIMEOUT_STEPS == 8'h00 |-> app_lim == `RS_APP_DEF_MS && bus_lim >= `RS_BUS_MIN_MS;
  endproperty
  a_app_def: assert property (p_app_def) else $error("timeout limits wrong");

  c_init_b: cover property (q.phase == redsw_pkg::PH_INIT ##1 q.phase == redsw_pkg::PH_RUN && SEL_B);
  c_auto: cover property (q.phase == redsw_pkg::PH_RUN && auto_go && !man_a && !man_b);
  c_manual: cover property (man_b ##[1:50] man_a);

endmodule : redundancy_switch

`default_nettype wire

// ### shared/redsw_consts.svh
// constants for the bus master redundancy switch
// assumes a 20 MHz system clock and a millisecond tick derived from it
`ifndef REDSW_CONSTS_SVH
`define REDSW_CONSTS_SVH

// clock rate and millisecond tick period
`define RS_CLK_MHZ 20
`define RS_TICK_US 1000
`define RS_TICK_W 15
`define RS_MS_W 16

// supervision times in milliseconds
`define RS_BUS_MIN_MS 16'h000a
`define RS_APP_STEP_MS 16'h000a
`define RS_APP_DEF_MS 16'h00c8
`define RS_MS_SAT 16'hffff

// station address switch
`define RS_ADDR_W 7
`define RS_ADDR_MAX 7'h63

// trigger mode codes
`define RS_TRIG_PROTO 2'h0
`define RS_TRIG_APP 2'h1
`define RS_TRIG_NET 2'h2

// output image byte 0 bit positions
`define RS_CMD_TO_A 0
`define RS_CMD_TO_B 1

// input image byte 0 bit positions
`define RS_ST_RUN 0
`define RS_ST_POS 1
`define RS_ST_ALIVE_A 2
`define RS_ST_ALIVE_B 3
`define RS_ST_RSVD 4'h0

`endif

// ### shared/redsw_pkg.sv
// state types of the redundancy switch modules
// assumes redsw_consts.svh on the include path
`include "redsw_consts.svh"

package redsw_pkg;

  typedef enum logic {PH_INIT, PH_RUN} phase_t;

  typedef struct packed {
    logic [7:0] s1;
    logic [7:0] s2;
  } sync_state_t;

  typedef struct packed {
    logic seen;
    logic [1:0] prev_cmd;
    logic [7:0] prev_alive;
    logic armed;
    logic bus_seen;
    logic [`RS_MS_W-1:0] bus_cnt;
    logic [`RS_MS_W-1:0] app_cnt;
    logic to_a;
    logic to_b;
    logic [7:0] echo;
  } sup_state_t;

  typedef struct packed {
    phase_t phase;
    logic sel_b;
    logic [`RS_TICK_W-1:0] tick_cnt;
    logic tick;
    logic [`RS_ADDR_W-1:0] addr;
    logic addr_ok;
    logic [7:0] state_a;
    logic [7:0] state_b;
    logic [7:0] echo_a;
    logic [7:0] echo_b;
  } top_state_t;

endpackage : redsw_pkg
